// ---- rtl/lcrs_pkg.sv ----
// constants and types of the logic clock rate selector
// assumes a 250 MHz reference clock and an AHB-Lite register bus
package lcrs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PS   = 4000;
  localparam int FAST_NS  = 1000;
  localparam int MID_NS   = 10000;
  localparam int SLOW_MS  = 100;
  localparam int DEB_MS   = 5;
  localparam int FAST_CYC = (FAST_NS * 1000) / CLK_PS;
  localparam int MID_CYC  = (MID_NS * 1000) / CLK_PS;
  localparam int SLOW_CYC = (SLOW_MS * 1000000) / (CLK_PS / 1000);
  localparam int DEB_CYC  = (DEB_MS * 1000000) / (CLK_PS / 1000);
  localparam int CNT_W    = 25;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRESS  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PULSES = 8'h0c;
  localparam int CTRL_REMOTE_BIT    = 0;
  localparam int PRESS_RATE_LSB     = 0;
  localparam int PRESS_MODE_LSB     = 4;
  localparam logic CTRL_REMOTE_RST  = 1'b0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    RATE_FAST, RATE_MID, RATE_SLOW, RATE_STEP
  } lcrs_rate_t;

  typedef enum logic [1:0] {
    MODE_PATCH, MODE_CLEAR, MODE_STOP, MODE_RUN
  } lcrs_mode_t;

  typedef struct packed {
    logic [21:0] zero;
    logic        remote;
    logic [2:0]  lamps;
    lcrs_mode_t  mode;
    lcrs_rate_t  act;
    lcrs_rate_t  sel;
  } lcrs_status_t;

endpackage

// ---- rtl/lcrs_top.sv ----
// logic clock rate selector: panel, software and remote selection of
// the logic clock rate and logic mode, and the logic clock generator
// assumes synchronous panel inputs and a single AHB-Lite master
`timescale 1ns/1ns
`default_nettype none

module lcrs_top
  import lcrs_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_CYC,
  parameter int DEB_CYCLES  = DEB_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // panel pushbuttons: fast, mid, slow, step / patch, clear, stop, run
  input  wire logic [3:0]  rate_btn_i,
  input  wire logic [3:0]  mode_btn_i,
  // remote source, one-cycle presses
  input  wire logic [3:0]  remote_rate_i,
  input  wire logic [3:0]  remote_mode_i,
  // outputs
  output logic             logic_clk_o,
  output logic      [2:0]  rate_lamp_o,
  output lcrs_mode_t       logic_mode_o,
  output logic             remote_control_select_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [1:0] pick(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] period_of(input lcrs_rate_t r);
    logic [CNT_W-1:0] p;
    case (r)
      RATE_FAST: p = CNT_W'(FAST_CYC);
      RATE_MID:  p = CNT_W'(MID_CYC);
      RATE_SLOW: p = CNT_W'(SLOW_CYCLES);
      default:   p = CNT_W'(1);
    endcase
    return p;
  endfunction

  // ****************************************
  // state
  // ****************************************
  lcrs_rate_t       sel_reg;
  lcrs_rate_t       act_reg;
  lcrs_mode_t       mode_reg;
  logic             remote_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             pulse_reg;
  logic [15:0]      npulse_reg;
  logic [CNT_W-1:0] deb_cnt_reg;
  logic             deb_reg;
  logic             ap_wr_reg;
  logic [7:0]       ap_addr_reg;
  logic [31:0]      rdata_reg;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // no wait states; every access answers OKAY, unmapped reads give 0
  // read data is captured in the address phase, so a read issued during a
  // write data phase still sees the value from before that write
  wire        ap_take  = hsel_i & htrans_i[1] & hready_i;
  wire        dp_write = ap_wr_reg;
  wire        wr_ctrl  = dp_write & (ap_addr_reg == OFS_CTRL);
  wire        wr_press = dp_write & (ap_addr_reg == OFS_PRESS);
  wire [3:0]  sw_rate  = wr_press ? hwdata_i[PRESS_RATE_LSB +: 4] : 4'h0;
  wire [3:0]  sw_mode  = wr_press ? hwdata_i[PRESS_MODE_LSB +: 4] : 4'h0;
  wire [7:0]  rd_addr  = haddr_i[7:0];
  wire        rd_take  = ap_take & ~hwrite_i;
  lcrs_status_t status;
  logic [31:0] rd_mux;

  assign status.zero   = 22'h0;
  assign status.remote = remote_reg;
  assign status.lamps  = rate_lamp_o;
  assign status.mode   = mode_reg;
  assign status.act    = act_reg;
  assign status.sel    = sel_reg;

  always_comb begin
    case (rd_addr)
      OFS_CTRL:   rd_mux = {31'h0, remote_reg};
      OFS_STATUS: rd_mux = status;
      OFS_PULSES: rd_mux = {16'h0, npulse_reg};
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_wr_reg   <= 1'b0;
      ap_addr_reg <= 8'h0;
      rdata_reg   <= 32'h0;
    end else begin
      ap_wr_reg   <= ap_take & hwrite_i;
      ap_addr_reg <= ap_take ? haddr_i[7:0] : ap_addr_reg;
      rdata_reg   <= rd_take ? rd_mux : rdata_reg;
    end
  end

  assign hrdata_o    = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************
  // step button debounce
  // ****************************************
  // a bouncing contact would otherwise fire several steps per press
  wire deb_diff = rate_btn_i[3] ^ deb_reg;
  wire deb_hit  = deb_diff & (deb_cnt_reg == CNT_W'(DEB_CYCLES - 1));
  wire step_loc = deb_hit & rate_btn_i[3];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deb_cnt_reg <= '0;
      deb_reg     <= 1'b0;
    end else begin
      deb_cnt_reg <= (deb_diff & ~deb_hit) ? deb_cnt_reg + 1'b1 : '0;
      deb_reg     <= deb_hit ? rate_btn_i[3] : deb_reg;
    end
  end

  // ****************************************
  // selection
  // ****************************************
  wire [3:0] rem_rate  = remote_reg ? remote_rate_i : 4'h0;
  wire [3:0] rem_mode  = remote_reg ? remote_mode_i : 4'h0;
  wire [3:0] rate_hit  = {step_loc, rate_btn_i[2:0]} | sw_rate | rem_rate;
  wire [3:0] mode_hit  = mode_btn_i | sw_mode | rem_mode;
  wire       in_step   = (sel_reg == RATE_STEP) & (act_reg == RATE_STEP);
  // a step press while stepping is a pulse, not a new selection
  wire       step_go   = in_step & rate_hit[3];
  wire       sel_any   = |rate_hit & ~step_go;
  wire       stop      = (mode_reg == MODE_STOP);
  wire [CNT_W-1:0] per = period_of(act_reg);
  wire       wrap      = (cnt_reg == per - 1'b1);
  wire       free      = (act_reg != RATE_STEP);
  wire       boundary  = ~free | stop | wrap;
  wire       pulse_nx  = ~stop & ((free & wrap) | step_go);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_reg    <= RATE_FAST;
      mode_reg   <= MODE_RUN;
      remote_reg <= CTRL_REMOTE_RST;
    end else begin
      sel_reg    <= sel_any ? lcrs_rate_t'(pick(rate_hit)) : sel_reg;
      mode_reg   <= |mode_hit ? lcrs_mode_t'(pick(mode_hit)) : mode_reg;
      remote_reg <= wr_ctrl ? hwdata_i[CTRL_REMOTE_BIT] : remote_reg;
    end
  end

  // ****************************************
  // logic clock generator
  // ****************************************
  // pulses are one reference cycle wide, so a boundary change is clean
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_reg    <= RATE_FAST;
      cnt_reg    <= '0;
      pulse_reg  <= 1'b0;
      npulse_reg <= 16'h0;
    end else begin
      act_reg    <= boundary ? sel_reg : act_reg;
      cnt_reg    <= (boundary) ? '0 : cnt_reg + 1'b1;
      pulse_reg  <= pulse_nx;
      npulse_reg <= npulse_reg + {15'h0, pulse_nx};
    end
  end

  assign logic_clk_o  = pulse_reg;
  assign logic_mode_o = mode_reg;
  assign remote_control_select_o = remote_reg;
  assign rate_lamp_o  = (sel_reg == RATE_STEP) ? 3'h0 :
                        3'(3'h1 << sel_reg);

  // ****************************************
  // checks
  // ****************************************
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // cycles since the last pulse; clean_reg says that gap spans one
  // free-running period with no stop and no stepping in between
  // a period is timed by the rate of the cycle before its closing pulse,
  // since the active rate switches on the very edge that raises it
  logic [CNT_W-1:0] gap_reg;
  logic             clean_reg;
  logic [3:0]       hit_prev_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_reg      <= '0;
      clean_reg    <= 1'b0;
      hit_prev_reg <= 4'h0;
    end else begin
      gap_reg      <= pulse_reg ? '0 : gap_reg + 1'b1;
      clean_reg    <= pulse_reg | (clean_reg & ~stop & free);
      hit_prev_reg <= rate_hit;
    end
  end

  sequence seq_step_press;
    step_go && !stop;
  endsequence

  sequence seq_one_pulse;
    logic_clk_o ##1 !logic_clk_o;
  endsequence

  chk_rate_lamps_excl: assert property (
    $onehot0(rate_lamp_o))
    else $error("rate lamps not exclusive");

  // the new selection must be one of the rates pressed just before
  chk_rate_pick: assert property (
    sel_any |=> hit_prev_reg[sel_reg])
    else $error("selected rate was not pressed");

  chk_fast_gap: assert property (
    logic_clk_o && clean_reg && $past(act_reg) == RATE_FAST
      |-> gap_reg == CNT_W'(FAST_CYC - 1))
    else $error("fast rate period wrong");

  chk_mid_gap: assert property (
    logic_clk_o && clean_reg && $past(act_reg) == RATE_MID
      |-> gap_reg == CNT_W'(MID_CYC - 1))
    else $error("mid rate period wrong");

  chk_slow_gap: assert property (
    logic_clk_o && clean_reg && $past(act_reg) == RATE_SLOW
      |-> gap_reg == CNT_W'(SLOW_CYCLES - 1))
    else $error("slow rate period wrong");

  chk_step_silent: assert property (
    logic_clk_o |-> $past(free || step_go))
    else $error("pulse in step mode without press");

  chk_step_once: assert property (
    seq_step_press |=> seq_one_pulse)
    else $error("step press did not give one pulse");

  chk_lamp_step_dark: assert property (
    sel_reg == RATE_STEP |-> rate_lamp_o == 3'h0)
    else $error("lamp lit in step mode");

  chk_remote_gate: assert property (
    !remote_reg && remote_rate_i != 4'h0 && rate_btn_i == 4'h0
      && sw_rate == 4'h0 && !step_loc |=> $stable(sel_reg))
    else $error("remote press taken while not remote");

  chk_stop_quiet: assert property (
    stop |=> !logic_clk_o)
    else $error("logic clock ran in stop mode");

  chk_step_debounce: assert property (
    step_loc |-> $past(rate_btn_i[3]) && !deb_reg)
    else $error("step edge without stable press");

  chk_rate_boundary: assert property (
    act_reg != $past(act_reg) |-> $past(boundary))
    else $error("rate changed inside a period");

endmodule

`default_nettype wire

// ---- test/lcrs_remote_model.sv ----
// remote source model: host computer or master console pressing buttons
// assumes the selector samples each press on one rising edge
`timescale 1ns/1ns
`default_nettype none

module lcrs_remote_model (
  // clock
  input  wire logic       ref_clk_i,
  // remote press lines
  output logic      [3:0] rate_o,
  output logic      [3:0] mode_o
);
  initial begin
    rate_o = 4'h0;
    mode_o = 4'h0;
  end

  // one press lasts one cycle, rate and mode in parallel
  task automatic press(input logic [3:0] r, input logic [3:0] m);
    @(posedge ref_clk_i);
    rate_o <= r;
    mode_o <= m;
    @(posedge ref_clk_i);
    rate_o <= 4'h0;
    mode_o <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ---- test/lcrs_top_bench.sv ----
// bench of the logic clock rate selector: bus tasks, panel and remote
// assumes short slow and debounce counts so the run stays brief
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module lcrs_top_bench;
  import lcrs_pkg::*;
  localparam int SLOW_N = 40;
  localparam int DEB_N  = 4;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [3:0]  rate_btn_i = 4'h0;
  logic [3:0]  mode_btn_i = 4'h0;
  logic [3:0]  rem_rate;
  logic [3:0]  rem_mode;
  logic        logic_clk_o;
  logic [2:0]  rate_lamp_o;
  lcrs_mode_t  logic_mode_o;
  logic        remote_control_select_o;
  int          bad_count = 0;
  int          n_tests = 0;
  int          pulse_n = 0;
  int          p;
  int          n0;
  logic [31:0] d;

  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (logic_clk_o === 1'b1) pulse_n <= pulse_n + 1;

  lcrs_top #(.SLOW_CYCLES(SLOW_N), .DEB_CYCLES(DEB_N)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rate_btn_i(rate_btn_i), .mode_btn_i(mode_btn_i),
    .remote_rate_i(rem_rate), .remote_mode_i(rem_mode),
    .logic_clk_o(logic_clk_o), .rate_lamp_o(rate_lamp_o),
    .logic_mode_o(logic_mode_o),
    .remote_control_select_o(remote_control_select_o));

  lcrs_remote_model remote (
    .ref_clk_i(ref_clk_i), .rate_o(rem_rate), .mode_o(rem_mode));

  // ****************************************
  // bus and panel tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    `CHK(hresp_o, 1'b0)
    // idle cycle so a check right after the task sees the write
    @(posedge ref_clk_i);
  endtask

  task automatic step_btn(input logic [3:0] b);
    rate_btn_i <= b;
    repeat (DEB_N + 4) @(posedge ref_clk_i);
    rate_btn_i <= 4'h0;
    repeat (DEB_N + 6) @(posedge ref_clk_i);
  endtask

  // edges between two pulses; each pulse one cycle wide
  task automatic period(output int n);
    while (logic_clk_o !== 1'b1) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    `CHK(logic_clk_o, 1'b0)
    n = 1;
    while (logic_clk_o !== 1'b1) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, OFS_STATUS, 32'h0, d);
    `CHK(d, 32'h0000_0070)
    `CHK(rate_lamp_o, 3'b001)
    bus(1'b1, 8'h10, 32'h1, d);
    bus(1'b0, 8'h10, 32'h0, d);
    `CHK(d, 32'h0)
    bus(1'b0, OFS_CTRL, 32'h0, d);
    `CHK(d, 32'h0)
    period(p);
    period(p);
    `CHK(p, 250)
    $display("test reset and fast done");
    rate_btn_i <= 4'b0010;
    @(posedge ref_clk_i);
    rate_btn_i <= 4'h0;
    repeat (2) @(posedge ref_clk_i);
    `CHK(rate_lamp_o, 3'b010)
    period(p);
    period(p);
    `CHK(p, 2500)
    bus(1'b1, OFS_PRESS, 32'h4, d);
    `CHK(rate_lamp_o, 3'b100)
    period(p);
    period(p);
    `CHK(p, SLOW_N)
    $display("test rates done");
    step_btn(4'b1000);
    `CHK(rate_lamp_o, 3'b000)
    repeat (60) @(posedge ref_clk_i);
    n0 = pulse_n;
    repeat (200) @(posedge ref_clk_i);
    `CHK(pulse_n - n0, 0)
    step_btn(4'b1000);
    step_btn(4'b1000);
    `CHK(pulse_n - n0, 2)
    $display("test step done");
    bus(1'b1, OFS_PRESS, 32'h40, d);
    `CHK(logic_mode_o, MODE_STOP)
    n0 = pulse_n;
    step_btn(4'b1000);
    `CHK(pulse_n - n0, 0)
    bus(1'b0, OFS_PULSES, 32'h0, d);
    `CHK(d, 32'(pulse_n))
    bus(1'b1, OFS_PRESS, 32'h81, d);
    `CHK(logic_mode_o, MODE_RUN)
    `CHK(rate_lamp_o, 3'b001)
    $display("test stop done");
    remote.press(4'b0010, 4'h0);
    repeat (2) @(posedge ref_clk_i);
    `CHK(rate_lamp_o, 3'b001)
    bus(1'b1, OFS_CTRL, 32'h1, d);
    `CHK(remote_control_select_o, 1'b1)
    remote.press(4'b0010, 4'b0010);
    repeat (2) @(posedge ref_clk_i);
    `CHK(rate_lamp_o, 3'b010)
    `CHK(logic_mode_o, MODE_CLEAR)
    bus(1'b0, OFS_STATUS, 32'h0, d);
    `CHK(d[9], 1'b1)
    mode_btn_i <= 4'b0001;
    @(posedge ref_clk_i);
    mode_btn_i <= 4'h0;
    repeat (2) @(posedge ref_clk_i);
    `CHK(logic_mode_o, MODE_PATCH)
    $display("test remote done");
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
